// ==== inc/smc_pkg.sv ====
package smc_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h05;
  localparam logic [7:0] ADDR_INTR_EN = 8'h06;
  localparam logic [7:0] ADDR_OPSTATE = 8'h07;
  localparam logic [7:0] ADDR_INT_STAT = 8'h14;

  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] INTR_EN_RST = 8'h00;
  localparam logic [7:0] OPSTATE_RST = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // Writable bits of the interrupt enable register
  localparam logic [7:0] IE_WMASK = 8'hDF;
  // Bits that gate an event source; FIFO sources never appear here
  localparam logic [7:0] IE_SRC_MASK = 8'h9F;

  // ----------------------------------------
  // Operating state codes
  // ----------------------------------------
  localparam logic [1:0] ST_SLEEP = 2'h0;
  localparam logic [1:0] ST_WAKE = 2'h1;
  localparam logic [1:0] ST_RSVD = 2'h2;
  localparam logic [1:0] ST_STANDBY = 2'h3;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_RES_BIT = 2;
  localparam int STAT_WDT_BIT = 4;
  localparam int STAT_OTP_BIT = 7;
  localparam int IE_TILT_BIT = 0;
  localparam int IE_FLIP_BIT = 1;
  localparam int IE_ANYM_BIT = 2;
  localparam int IE_SHAKE_BIT = 3;
  localparam int IE_STEEP_BIT = 4;
  localparam int IE_AUTO_BIT = 6;
  localparam int IE_SAMPLE_BIT = 7;
  localparam int OP_STATE_LSB = 0;
  localparam int OP_LOW_WD_BIT = 4;
  localparam int OP_HIGH_WD_BIT = 5;
  localparam logic RES_16BIT = 1'b0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int WD_TIMEOUT_US = 1000;
  localparam int WD_TIMEOUT_CYC = WD_TIMEOUT_US * CLK_MHZ;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic steep_tilt_enable;
    logic shake_detect_enable;
    logic any_motion_enable;
    logic tilt_flip_enable;
  } smc_motion_ctrl_t;

  typedef struct packed {
    logic steep;
    logic shake;
    logic any_motion;
    logic flip;
    logic tilt;
  } smc_motion_cond_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } smc_reg_req_t;

endpackage : smc_pkg

// ==== hw/smc_sync2.sv ====
`timescale 1ns/1ps
module smc_sync2
  import smc_pkg::*;
(
  // Clock and reset
  input logic clk,
  input logic srst,
  // Asynchronous level in, synchronised level out
  input logic d,
  output logic q
);

  logic meta_r;
  logic q_r;

  // First stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_r <= 1'b1;
      q_r <= 1'b1;
    end
    else
    begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule : smc_sync2

// ==== hw/smc_bus_watchdog.sv ====
`timescale 1ns/1ps
module smc_bus_watchdog
  import smc_pkg::*;
#(
  parameter int TIMEOUT_CYC = WD_TIMEOUT_CYC
)
(
  // Clock and reset
  input logic clk,
  input logic srst,
  // Bus view
  input logic scl_s,
  input logic bus_active,
  input logic low_en,
  input logic high_en,
  // One-cycle timeout pulse
  output logic timeout
);

  localparam int CW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(TIMEOUT_CYC - 1);

  typedef enum logic [1:0] {WD_IDLE, WD_LOW, WD_HIGH, WD_TRIP} smc_wd_st_t;

  smc_wd_st_t st_r;
  logic [CW-1:0] cnt_r;
  logic timeout_r;
  logic armed;
  logic lvl_hold;

  assign armed = scl_s ? high_en : low_en;
  assign lvl_hold = (st_r == WD_HIGH) ? scl_s : !scl_s;

  // Trip state waits for bus_active to drop so one stall gives one pulse
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_r <= WD_IDLE;
      cnt_r <= '0;
      timeout_r <= 1'b0;
    end
    else
    begin
      timeout_r <= 1'b0;
      case (st_r)
        WD_IDLE:
        begin
          cnt_r <= '0;
          if (bus_active && armed)
            st_r <= scl_s ? WD_HIGH : WD_LOW;
        end
        WD_LOW, WD_HIGH:
        begin
          if (!bus_active || !lvl_hold || !armed)
            st_r <= WD_IDLE;
          else if (cnt_r == CNT_LAST)
          begin
            timeout_r <= 1'b1;
            st_r <= WD_TRIP;
          end
          else
            cnt_r <= cnt_r + 1'b1;
        end
        WD_TRIP:
        begin
          if (!bus_active)
            st_r <= WD_IDLE;
        end
        default:
          st_r <= WD_IDLE;
      endcase
    end
  end

  assign timeout = timeout_r;

endmodule : smc_bus_watchdog

// ==== hw/smc_ctrl.sv ====
`timescale 1ns/1ps
// What this block does
// - Status reports operating state: 00 sleep, 01 wake, 11 standby
// - Host writes state field; device enters it, running clocks accordingly
// - Operating-state register accepts writes in any state, sleep included
// - Resolution bit always reads 0, meaning 16-bit resolution
// - Watchdog timeout sets status bit 4 and idles the serial slave
// - Reading status clears the watchdog flag
// - Status bit 7 shows memory-load busy; host waits while set
// - Tilt enable bit 0 reports tilt only with tilt_flip_enable
// - Flip enable bit 1 reports flip only with tilt_flip_enable
// - Any-motion enable bit 2 reports only with any_motion_enable
// - Shake enable bit 3 needs shake and any-motion enables
// - Steep-tilt enable bit 4 needs steep-tilt and any-motion enables
// - Without auto clear, pending stays until host writes the interrupt status register
// - With auto clear, pending drops once its condition is gone
// - Sample enable bit 7 flags every acquired sample; off by default
// - Interrupt enable register never touches FIFO interrupts
// - Bit 4 enables low-stall bus watchdog; off at reset
// - Bit 5 enables high-stall bus watchdog; off at reset
// - Op-state and interrupt enable registers read back; status ignores writes; interrupt status register reads zero
module smc_ctrl
  import smc_pkg::*;
#(
  parameter int WD_TIMEOUT = WD_TIMEOUT_CYC
)
(
  // Clock and reset
  input logic clk,
  input logic srst,
  // Register access from the serial slave
  input smc_reg_req_t req,
  output logic [7:0] rdata,
  // Serial bus view
  input logic scl_pin,
  input logic bus_active,
  output logic slave_idle,
  // Motion block and sampler
  input smc_motion_ctrl_t motion_ctrl,
  input smc_motion_cond_t motion_cond,
  input logic sample_done,
  input logic otp_busy,
  // Operating state
  output logic [1:0] op_state,
  output logic clocks_run,
  output logic sampling_run,
  // Pending interrupt flags
  output logic [7:0] irq_pending
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic hit(input smc_reg_req_t q,
                               input logic [7:0] a);
    hit = (q.addr == a);
  endfunction : hit

  logic wr_op;
  logic wr_ie;
  logic wr_istat;
  logic rd_stat;

  // Status is read-only: no write strobe exists for it
  assign wr_op = req.wr && hit(req, ADDR_OPSTATE);
  assign wr_ie = req.wr && hit(req, ADDR_INTR_EN);
  assign wr_istat = req.wr && hit(req, ADDR_INT_STAT);
  assign rd_stat = req.rd && hit(req, ADDR_STATUS);

  // ----------------------------------------
  // Operating state register
  // ----------------------------------------
  logic [1:0] state_r;
  logic low_wd_en_r;
  logic high_wd_en_r;
  logic [1:0] wr_state;

  assign wr_state = req.wdata[OP_STATE_LSB +: 2];

  // Accepted in any state; reserved code keeps the old state
  always_ff @(posedge clk)
  begin
    if (srst)
      state_r <= OPSTATE_RST[OP_STATE_LSB +: 2];
    else if (wr_op && wr_state != ST_RSVD)
      state_r <= wr_state;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      low_wd_en_r <= OPSTATE_RST[OP_LOW_WD_BIT];
      high_wd_en_r <= OPSTATE_RST[OP_HIGH_WD_BIT];
    end
    else if (wr_op)
    begin
      low_wd_en_r <= req.wdata[OP_LOW_WD_BIT];
      high_wd_en_r <= req.wdata[OP_HIGH_WD_BIT];
    end
  end

  // Clocks stop only in sleep; sampling only in wake
  assign op_state = state_r;
  assign clocks_run = (state_r != ST_SLEEP);
  assign sampling_run = (state_r == ST_WAKE);

  // ----------------------------------------
  // Bus watchdog
  // ----------------------------------------
  logic scl_s;
  logic wd_timeout;
  logic wdt_flag_r;
  logic slave_idle_r;

  smc_sync2 u_scl_sync (
    .clk(clk),
    .srst(srst),
    .d(scl_pin),
    .q(scl_s)
  );

  smc_bus_watchdog #(
    .TIMEOUT_CYC(WD_TIMEOUT)
  ) u_watchdog (
    .clk(clk),
    .srst(srst),
    .scl_s(scl_s),
    .bus_active(bus_active),
    .low_en(low_wd_en_r),
    .high_en(high_wd_en_r),
    .timeout(wd_timeout)
  );

  // New event wins over the clear by a status read
  always_ff @(posedge clk)
  begin
    if (srst)
      wdt_flag_r <= STATUS_RST[STAT_WDT_BIT];
    else if (wd_timeout)
      wdt_flag_r <= 1'b1;
    else if (rd_stat)
      wdt_flag_r <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      slave_idle_r <= 1'b0;
    else
      slave_idle_r <= wd_timeout;
  end

  assign slave_idle = slave_idle_r;

  // ----------------------------------------
  // Interrupt enable register
  // ----------------------------------------
  logic [7:0] ie_r;

  always_ff @(posedge clk)
  begin
    if (srst)
      ie_r <= INTR_EN_RST;
    else if (wr_ie)
      ie_r <= req.wdata & IE_WMASK;
  end

  // ----------------------------------------
  // Pending interrupt flags
  // ----------------------------------------
  logic [7:0] src_vec;
  logic [7:0] gated;
  logic [7:0] pend_r;
  logic [7:0] pend_nxt;
  logic auto_clr;

  assign auto_clr = ie_r[IE_AUTO_BIT];

  // Motion enables are qualified here, not in the motion block
  always_comb
  begin
    src_vec = ZERO_BYTE;
    src_vec[IE_TILT_BIT] = motion_cond.tilt &&
      motion_ctrl.tilt_flip_enable;
    src_vec[IE_FLIP_BIT] = motion_cond.flip &&
      motion_ctrl.tilt_flip_enable;
    src_vec[IE_ANYM_BIT] = motion_cond.any_motion &&
      motion_ctrl.any_motion_enable;
    src_vec[IE_SHAKE_BIT] = motion_cond.shake &&
      motion_ctrl.shake_detect_enable &&
      motion_ctrl.any_motion_enable;
    src_vec[IE_STEEP_BIT] = motion_cond.steep &&
      motion_ctrl.steep_tilt_enable &&
      motion_ctrl.any_motion_enable;
    src_vec[IE_SAMPLE_BIT] = sample_done;
  end

  // Mask keeps auto-clear and reserved bits out; FIFO never enters
  assign gated = src_vec & ie_r & IE_SRC_MASK;

  // Set wins over either kind of clear
  always_comb
  begin
    pend_nxt = pend_r;
    for (int i = 0; i < 8; i++)
    begin
      if (gated[i])
        pend_nxt[i] = 1'b1;
      else if (wr_istat)
        pend_nxt[i] = 1'b0;
      else if (auto_clr)
        pend_nxt[i] = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      pend_r <= ZERO_BYTE;
    else
      pend_r <= pend_nxt;
  end

  assign irq_pending = pend_r;

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  logic [7:0] stat_word;
  logic [7:0] op_word;
  logic [7:0] rd_mux;
  logic [7:0] rdata_r;

  // Reserved bits read zero; bit 2 of the state register stays zero
  always_comb
  begin
    stat_word = ZERO_BYTE;
    stat_word[STAT_STATE_LSB +: 2] = state_r;
    stat_word[STAT_RES_BIT] = RES_16BIT;
    stat_word[STAT_WDT_BIT] = wdt_flag_r;
    stat_word[STAT_OTP_BIT] = otp_busy;
    op_word = ZERO_BYTE;
    op_word[OP_STATE_LSB +: 2] = state_r;
    op_word[OP_LOW_WD_BIT] = low_wd_en_r;
    op_word[OP_HIGH_WD_BIT] = high_wd_en_r;
    case (req.addr)
      ADDR_STATUS: rd_mux = stat_word;
      ADDR_INTR_EN: rd_mux = ie_r;
      ADDR_OPSTATE: rd_mux = op_word;
      default: rd_mux = ZERO_BYTE;
    endcase
  end

  // Data holds until the next read
  always_ff @(posedge clk)
  begin
    if (srst)
      rdata_r <= ZERO_BYTE;
    else if (req.rd)
      rdata_r <= rd_mux;
  end

  assign rdata = rdata_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_STATE_CODES:
    assert property (@(posedge clk) disable iff (srst)
      state_r != ST_RSVD && sampling_run == (state_r == ST_WAKE))
    else $error("state code or sampling output wrong");

  AST_WAKE_ENTRY:
    assert property (@(posedge clk) disable iff (srst)
      wr_op && wr_state == ST_WAKE |=> clocks_run && sampling_run)
    else $error("wake write did not start sampling");

  AST_STANDBY_ACCEPT:
    assert property (@(posedge clk) disable iff (srst)
      wr_op && wr_state == ST_STANDBY && state_r == ST_WAKE
      |=> state_r == ST_STANDBY && !sampling_run)
    else $error("standby write ignored in wake");

  AST_RES_ZERO:
    assert property (@(posedge clk) disable iff (srst)
      rd_stat |=> !rdata_r[STAT_RES_BIT])
    else $error("resolution bit read as one");

  AST_WDT_SET:
    assert property (@(posedge clk) disable iff (srst)
      wd_timeout |=> wdt_flag_r && slave_idle)
    else $error("watchdog event not flagged");

  AST_WDT_READ_CLR:
    assert property (@(posedge clk) disable iff (srst)
      rd_stat && !wd_timeout && wdt_flag_r
      |=> rdata_r[STAT_WDT_BIT] && !wdt_flag_r)
    else $error("status read did not clear watchdog flag");

  AST_OTP_REPORT:
    assert property (@(posedge clk) disable iff (srst)
      rd_stat |=> rdata_r[STAT_OTP_BIT] == $past(otp_busy))
    else $error("busy bit misreported");

  AST_SHAKE_GATE:
    assert property (@(posedge clk) disable iff (srst)
      $rose(pend_r[IE_SHAKE_BIT]) |-> $past(ie_r[IE_SHAKE_BIT] &&
      motion_ctrl.shake_detect_enable && motion_ctrl.any_motion_enable))
    else $error("shake flagged without enables");

  AST_TILT_GATE:
    assert property (@(posedge clk) disable iff (srst)
      $rose(pend_r[IE_TILT_BIT]) |->
      $past(ie_r[IE_TILT_BIT] && motion_ctrl.tilt_flip_enable))
    else $error("tilt flagged without enables");

  AST_FLIP_GATE:
    assert property (@(posedge clk) disable iff (srst)
      $rose(pend_r[IE_FLIP_BIT]) |->
      $past(ie_r[IE_FLIP_BIT] && motion_ctrl.tilt_flip_enable))
    else $error("flip flagged without enables");

  AST_ANYM_GATE:
    assert property (@(posedge clk) disable iff (srst)
      $rose(pend_r[IE_ANYM_BIT]) |->
      $past(ie_r[IE_ANYM_BIT] && motion_ctrl.any_motion_enable))
    else $error("any-motion flagged without enables");

  AST_STEEP_GATE:
    assert property (@(posedge clk) disable iff (srst)
      $rose(pend_r[IE_STEEP_BIT]) |-> $past(ie_r[IE_STEEP_BIT] &&
      motion_ctrl.steep_tilt_enable && motion_ctrl.any_motion_enable))
    else $error("steep tilt flagged without enables");

  AST_NO_FIFO_BITS:
    assert property (@(posedge clk) disable iff (srst)
      (irq_pending & ~IE_SRC_MASK) == ZERO_BYTE)
    else $error("pending flag outside the gated sources");

  AST_PEND_HOLD:
    assert property (@(posedge clk) disable iff (srst)
      pend_r[IE_TILT_BIT] && !auto_clr && !wr_istat
      |=> pend_r[IE_TILT_BIT])
    else $error("pending tilt lost without clear");

  AST_AUTO_CLR:
    assert property (@(posedge clk) disable iff (srst)
      auto_clr && !gated[IE_ANYM_BIT] |=> !pend_r[IE_ANYM_BIT])
    else $error("auto clear did not drop flag");

  AST_SAMPLE_FLAG:
    assert property (@(posedge clk) disable iff (srst)
      sample_done && ie_r[IE_SAMPLE_BIT] |=> pend_r[IE_SAMPLE_BIT])
    else $error("sample flag not raised");

  AST_WD_RESET_OFF:
    assert property (@(posedge clk)
      srst |=> !low_wd_en_r && !high_wd_en_r && ie_r == ZERO_BYTE)
    else $error("watchdog enables not cleared by reset");

endmodule : smc_ctrl

// ==== verification/smc_host_model.sv ====
`timescale 1ns/1ps
module smc_host_model
  import smc_pkg::*;
(
  // Clock
  input logic clk,
  // Register port
  output smc_reg_req_t req,
  input logic otp_busy
);
  initial req = '0;

  // ----------------------------------------
  // Bus cycle
  // ----------------------------------------
  // Barge skips the busy wait, only for a deliberate misuse
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [7:0] d, input logic barge);
    int n;
    n = 0;
    while (otp_busy !== 1'b0 && !barge && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req.addr = a;
    req.wr = w;
    req.rd = !w;
    req.wdata = (w && a == ADDR_OPSTATE) ? d & 8'hFB : d;
    @(negedge clk);
    req.wr = 1'b0;
    req.rd = 1'b0;
    // Stale data is not left on the lines
    req.wdata = ~req.wdata;
  endtask : acc
endmodule : smc_host_model

// ==== verification/test_smc_ctrl.sv ====
`timescale 1ns/1ps
module test_smc_ctrl
  import smc_pkg::*;
();
  logic clk = 1'b0;
  logic srst = 1'b1;
  smc_reg_req_t req;
  logic [7:0] rdata;
  logic [7:0] irq_pending;
  logic scl_pin, bus_active, slave_idle, sample_done, otp_busy;
  logic clocks_run, sampling_run, rd_d;
  logic [1:0] op_state;
  smc_motion_ctrl_t mc;
  smc_motion_cond_t cond;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] exp_q[$];

  always #20 clk = ~clk;

  smc_ctrl #(.WD_TIMEOUT(8)) smc_ctrl_inst (.clk(clk), .srst(srst),
    .req(req), .rdata(rdata), .scl_pin(scl_pin), .bus_active(bus_active),
    .slave_idle(slave_idle), .motion_ctrl(mc), .motion_cond(cond),
    .sample_done(sample_done), .otp_busy(otp_busy), .op_state(op_state),
    .clocks_run(clocks_run), .sampling_run(sampling_run),
    .irq_pending(irq_pending));
  smc_host_model smc_host_model_inst (.clk(clk), .req(req),
    .otp_busy(otp_busy));

  // ----------------------------------------
  // Compare and access tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    smc_host_model_inst.acc(1'b1, a, d, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic b = 1'b0);
    exp_q.push_back(e);
    smc_host_model_inst.acc(1'b0, a, 8'h00, b);
  endtask : rd

  function automatic logic [7:0] st(input logic [1:0] s, input logic w);
    return {3'h0, w, 1'b0, RES_16BIT, s};
  endfunction : st

  function automatic logic [7:0] gate(input smc_motion_ctrl_t c,
      input smc_motion_cond_t m, input logic [7:0] ie);
    logic [7:0] g;
    g = 8'h00;
    g[0] = m.tilt & c.tilt_flip_enable;
    g[1] = m.flip & c.tilt_flip_enable;
    g[2] = m.any_motion & c.any_motion_enable;
    g[3] = m.shake & c.shake_detect_enable & c.any_motion_enable;
    g[4] = m.steep & c.steep_tilt_enable & c.any_motion_enable;
    return g & ie;
  endfunction : gate

  task automatic end_sim();
    // A read whose data never came back is a mismatch too
    if (exp_q.size() != 0)
      err_count++;
    $display("checked %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // Read data watcher and timeout
  // ----------------------------------------
  always @(posedge clk) rd_d <= req.rd;

  always @(negedge clk)
    if (rd_d === 1'b1)
      chk(rdata, exp_q.pop_front());

  // Whole run needs well under two thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      end_sim();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [1:0] codes [6];
    logic [1:0] cur;
    logic [1:0] w;
    logic [7:0] ie;
    logic [7:0] pe;
    int n;
    codes = '{ST_WAKE, ST_STANDBY, ST_RSVD, ST_SLEEP, ST_STANDBY, ST_WAKE};
    cur = ST_SLEEP;
    scl_pin = 1'b1;
    bus_active = 1'b0;
    sample_done = 1'b0;
    otp_busy = 1'b0;
    mc = '0;
    cond = '0;
    void'($urandom(32'h496DEFB7));
    repeat (6) @(negedge clk);
    srst = 1'b0;
    rd(ADDR_STATUS, STATUS_RST);
    rd(ADDR_INTR_EN, INTR_EN_RST);
    rd(ADDR_OPSTATE, OPSTATE_RST);
    rd(8'h33, ZERO_BYTE);
    foreach (codes[i])
    begin
      w = 2'($urandom_range(2, 0));
      wr(ADDR_OPSTATE, {2'b00, w, 2'b01, codes[i]});
      if (codes[i] != ST_RSVD)
        cur = codes[i];
      chk({4'h0, op_state, clocks_run, sampling_run},
          {4'h0, cur, cur != ST_SLEEP, cur == ST_WAKE});
      rd(ADDR_STATUS, st(cur, 1'b0));
      rd(ADDR_OPSTATE, {2'b00, w, 2'b00, cur});
    end
    wr(ADDR_STATUS, 8'hFF);
    rd(ADDR_STATUS, st(cur, 1'b0));
    ie = 8'($urandom);
    wr(ADDR_INTR_EN, ie);
    rd(ADDR_INTR_EN, ie & IE_WMASK);
    // Auto clear off; one source kind at a time is not enforced here
    for (int i = 0; i < 20; i++)
    begin
      ie = 8'($urandom) & 8'h1F;
      wr(ADDR_INTR_EN, ie);
      mc = 4'($urandom);
      cond = 5'($urandom);
      pe = gate(mc, cond, ie);
      repeat (2) @(negedge clk);
      chk(irq_pending, pe);
      cond = '0;
      repeat (2) @(negedge clk);
      chk(irq_pending, pe);
      wr(ADDR_INT_STAT, 8'h00);
      chk(irq_pending, 8'h00);
    end
    wr(ADDR_INTR_EN, 8'h44);
    mc = '0;
    mc.any_motion_enable = 1'b1;
    cond.any_motion = 1'b1;
    repeat (2) @(negedge clk);
    chk(irq_pending, 8'h04);
    cond = '0;
    repeat (2) @(negedge clk);
    chk(irq_pending, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      ie = i ? 8'h80 : 8'h00;
      wr(ADDR_INTR_EN, ie);
      sample_done = 1'b1;
      @(negedge clk);
      sample_done = 1'b0;
      @(negedge clk);
      chk(irq_pending, ie);
      wr(ADDR_INT_STAT, 8'h00);
    end
    for (int j = 0; j < 3; j++)
    begin
      w = 2'(j);
      wr(ADDR_OPSTATE, {2'b00, w, 2'b00, ST_WAKE});
      scl_pin = (j == 2);
      bus_active = 1'b1;
      n = 0;
      while (slave_idle !== 1'b1 && n < 40)
      begin
        @(negedge clk);
        n++;
      end
      chk({7'h0, slave_idle}, {7'h0, j != 0});
      bus_active = 1'b0;
      scl_pin = 1'b1;
      rd(ADDR_STATUS, st(ST_WAKE, j != 0));
      rd(ADDR_STATUS, st(ST_WAKE, 1'b0));
    end
    otp_busy = 1'b1;
    rd(ADDR_STATUS, 8'h80 | st(ST_WAKE, 1'b0), 1'b1);
    fork
      begin
        repeat (5) @(negedge clk);
        otp_busy = 1'b0;
      end
    join_none
    rd(ADDR_STATUS, st(ST_WAKE, 1'b0));
    // Leave a flag pending so the mid-run reset has something to clear
    sample_done = 1'b1;
    @(negedge clk);
    sample_done = 1'b0;
    @(negedge clk);
    chk(irq_pending, 8'h80);
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    chk({clocks_run, sampling_run, slave_idle, 3'h0, op_state},
        ZERO_BYTE);
    chk(irq_pending, ZERO_BYTE);
    chk(rdata, ZERO_BYTE);
    rd(ADDR_OPSTATE, OPSTATE_RST);
    rd(ADDR_INTR_EN, INTR_EN_RST);
    repeat (3) @(negedge clk);
    end_sim();
  end
endmodule : test_smc_ctrl
